// File: verilog/flash_host.sv
`timescale 1ns/10ps
`default_nettype none

module flash_host
    import flash_host_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [7:0] cmd_op_i,
    input  wire logic [23:0] cmd_addr_i,
    input  wire logic [8:0] cmd_len_i,
    output logic            cmd_ready_o,
    input  wire logic [7:0] wr_data_i,
    output logic            wr_take_o,
    output logic [7:0]      rd_data_o,
    output logic            rd_valid_o,
    output logic            done_o,
    output logic            sck_o,
    output logic            cs_n_o,
    input  wire logic [1:0] dual_data_lines_i,
    output logic [1:0]      dual_data_lines_o,
    output logic [1:0]      dual_data_lines_oe_o
);

    typedef enum logic [2:0] {IDLE, LEAD, OPC, ADDR, DUMMY, WDATA, RDATA, TAIL} phase_t;

    typedef struct packed {
        phase_t     phase;
        logic       gap;
        logic       sck;
        logic       cs_n;
        logic [1:0] dq_out;
        logic [1:0] dq_oe;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [3:0] clks;
        logic       byte_end;
        logic       dual;
        logic [8:0] left;
        logic [1:0] abytes;
        logic [7:0] op;
        logic [23:0] addr;
        logic [8:0] len;
        logic       write_latch_set_cmd_pre;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       wr_take;
        logic       done;
        logic       ready;
        logic [1:0] sync1;
        logic [1:0] sync2;
    } state_t;

    state_t s;
    state_t next_s;
    info_t  info;
    info_t  cmd_info;
    logic   tick;

    sck_pacer pacer (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        // the deselect gap is paced too, else idle would never see its closing tick
        .run_i     ((s.phase != IDLE) || s.gap),
        .tick_o    (tick)
    );

    // line levels for the head of the shift register; dual puts the high bit on line 1
    function automatic logic [1:0] head(input logic [7:0] tx, input logic dual);
        return dual ? tx[7:6] : {1'b0, tx[7]};
    endfunction

    // the prefixed write enable frame carries nothing but its opcode
    assign info = s.write_latch_set_cmd_pre ? info_t'('0) : decode(s.op, s.len);
    assign cmd_info = decode(cmd_op_i, cmd_len_i);

    always_comb begin
        next_s          = s;
        next_s.sync1    = dual_data_lines_i;
        next_s.sync2    = s.sync1;
        next_s.rd_valid = 1'b0;
        next_s.wr_take  = 1'b0;
        next_s.done     = 1'b0;

        unique case (s.phase)
            IDLE: begin
                if (s.gap) begin
                    if (tick) begin
                        next_s.gap = 1'b0;
                    end
                end else if (s.write_latch_set_cmd_pre && s.op != WRITE_LATCH_SET_CMD) begin
                    next_s.write_latch_set_cmd_pre = 1'b0;
                end
                if (!s.ready && !s.gap && !s.write_latch_set_cmd_pre) begin
                    next_s.done  = 1'b1;
                    next_s.ready = 1'b1;
                end
                if (s.ready && cmd_valid_i) begin
                    next_s.ready = 1'b0;
                    next_s.op    = cmd_op_i;
                    next_s.len   = data_len(cmd_op_i, cmd_len_i);
                    next_s.addr  = cmd_addr_i & ARRAY_MASK;
                    if (cmd_op_i == SECTOR_ERASE_CMD || cmd_op_i == SECTOR_ERASE_ALT_CMD) begin
                        next_s.addr = cmd_addr_i & ARRAY_MASK & SECTOR_MASK;
                    end else if (cmd_op_i == BLOCK_ERASE_CMD) begin
                        next_s.addr = cmd_addr_i & ARRAY_MASK & BLOCK_MASK;
                    end
                    next_s.write_latch_set_cmd_pre = cmd_info.need_write_latch_set_cmd;
                end
                // a new frame opens: select first, opcode MSB on the line before any clock
                if ((s.ready && cmd_valid_i) || (s.write_latch_set_cmd_pre && !s.gap && !s.ready)) begin
                    next_s.phase  = LEAD;
                    next_s.cs_n   = 1'b0;
                    next_s.tx     = next_s.write_latch_set_cmd_pre ? WRITE_LATCH_SET_CMD : next_s.op;
                    next_s.dual   = 1'b0;
                    next_s.dq_out = head(next_s.tx, 1'b0);
                    next_s.dq_oe  = 2'b01;
                    next_s.clks   = CLKS_SINGLE;
                    next_s.byte_end = 1'b0;
                end
            end
            LEAD: begin
                if (tick) begin
                    next_s.phase = OPC;
                end
            end
            TAIL: begin
                // clock already back low; deselect a half period after the last falling edge
                if (tick) begin
                    next_s.cs_n  = 1'b1;
                    next_s.dq_oe = 2'b00;
                    next_s.phase = IDLE;
                    next_s.gap   = 1'b1;
                    if (s.write_latch_set_cmd_pre) begin
                        next_s.op = s.op;
                    end
                end
            end
            default: begin
                if (tick && !s.sck) begin
                    // rising edge: both host and device sample here
                    next_s.sck  = 1'b1;
                    next_s.clks = s.clks - 4'h1;
                    if (s.phase == RDATA) begin
                        next_s.rx = s.dual ? {s.rx[5:0], s.sync2} : {s.rx[6:0], s.sync2[1]};
                    end
                    if (s.clks == 4'h1) begin
                        next_s.byte_end = 1'b1;
                        if (s.phase == RDATA) begin
                            next_s.rd_data  = next_s.rx;
                            next_s.rd_valid = 1'b1;
                        end
                    end
                end else if (tick) begin
                    // falling edge: the host moves its own output bits here
                    next_s.sck = 1'b0;
                    if (!s.byte_end) begin
                        next_s.tx     = s.dual ? {s.tx[5:0], 2'b00} : {s.tx[6:0], 1'b0};
                        next_s.dq_out = head(next_s.tx, s.dual);
                    end else begin
                        next_s.byte_end = 1'b0;
                        next_s.tx       = 8'h00;
                        unique case (s.phase)
                            OPC: begin
                                next_s.left = info.rd || info.wr ? s.len : 9'h000;
                                if (info.has_addr) begin
                                    next_s.phase  = ADDR;
                                    next_s.abytes = ADDR_BYTES;
                                end else if (info.wr) begin
                                    next_s.phase = WDATA;
                                end else if (info.rd && s.len != 9'h000) begin
                                    next_s.phase = RDATA;
                                end else begin
                                    next_s.phase = TAIL;
                                end
                            end
                            ADDR: begin
                                next_s.abytes = s.abytes - 2'h1;
                                if (s.abytes == 2'h1) begin
                                    if (info.has_dummy) begin
                                        next_s.phase = DUMMY;
                                    end else if (info.wr) begin
                                        next_s.phase = WDATA;
                                    end else if (info.rd && s.left != 9'h000) begin
                                        next_s.phase = RDATA;
                                    end else begin
                                        next_s.phase = TAIL;
                                    end
                                end
                            end
                            DUMMY: begin
                                next_s.phase = s.left != 9'h000 ? RDATA : TAIL;
                            end
                            WDATA, RDATA: begin
                                next_s.left = s.left - 9'h001;
                                if (s.left == 9'h001) begin
                                    next_s.phase = TAIL;
                                end
                            end
                            default: next_s.phase = TAIL;
                        endcase
                        // the chosen phase fixes width, drive direction and first bits
                        next_s.dual = (next_s.phase == ADDR && info.dual_addr)
                                    || ((next_s.phase == DUMMY || next_s.phase == RDATA)
                                        && info.dual_data);
                        next_s.clks = next_s.dual ? CLKS_DUAL : CLKS_SINGLE;
                        if (next_s.phase == ADDR) begin
                            next_s.tx   = s.phase == OPC ? s.addr[23:16] :
                                          (s.abytes == 2'h3 ? s.addr[15:8] : s.addr[7:0]);
                        end else if (next_s.phase == WDATA) begin
                            next_s.tx      = wr_data_i;
                            next_s.wr_take = 1'b1;
                        end
                        unique case (next_s.phase)
                            ADDR:     next_s.dq_oe = next_s.dual ? 2'b11 : 2'b01;
                            DUMMY:    next_s.dq_oe = next_s.dual ? 2'b00 : 2'b01;
                            WDATA:    next_s.dq_oe = 2'b01;
                            default:  next_s.dq_oe = next_s.phase == TAIL ? s.dq_oe : 2'b00;
                        endcase
                        next_s.dq_out = head(next_s.tx, next_s.dual);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s       <= '0;
            s.phase <= IDLE;
            s.cs_n  <= 1'b1;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign cmd_ready_o          = s.ready;
    assign wr_take_o            = s.wr_take;
    assign rd_data_o            = s.rd_data;
    assign rd_valid_o           = s.rd_valid;
    assign done_o               = s.done;
    assign sck_o                = s.sck;
    assign cs_n_o               = s.cs_n;
    assign dual_data_lines_o    = s.dq_out;
    assign dual_data_lines_oe_o = s.dq_oe;

endmodule

`default_nettype wire

// File: verilog/flash_host_pkg.sv
package flash_host_pkg;

    // serial clock pacing: one half period of the link clock in reference cycles
    localparam int REF_CLK_MHZ  = 250;
    localparam int SCK_MAX_MHZ  = 25;
    localparam logic [2:0] HALF_CYC = 3'((REF_CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ));

    localparam logic [3:0] CLKS_SINGLE = 4'h8;
    localparam logic [3:0] CLKS_DUAL   = 4'h4;
    localparam logic [1:0] ADDR_BYTES  = 2'h3;
    localparam int         TOP_ADDRESS_BIT = 18;
    localparam logic [23:0] ARRAY_MASK  = 24'h07_FFFF;
    localparam logic [23:0] SECTOR_MASK = 24'hFF_F000;
    localparam logic [23:0] BLOCK_MASK  = 24'hFF_0000;
    localparam logic [8:0]  PAGE_BYTES  = 9'h100;

    localparam logic [7:0] READ_CMD               = 8'h03;
    localparam logic [7:0] FAST_READ_CMD          = 8'h0B;
    localparam logic [7:0] DUAL_OUT_READ_CMD      = 8'h3B;
    localparam logic [7:0] DUAL_IO_READ_CMD       = 8'hBB;
    localparam logic [7:0] SECTOR_ERASE_CMD       = 8'h20;
    localparam logic [7:0] SECTOR_ERASE_ALT_CMD   = 8'hD7;
    localparam logic [7:0] BLOCK_ERASE_CMD        = 8'hD8;
    localparam logic [7:0] CHIP_ERASE_CMD         = 8'h60;
    localparam logic [7:0] CHIP_ERASE_ALT_CMD     = 8'hC7;
    localparam logic [7:0] PAGE_PROGRAM_CMD       = 8'h02;
    localparam logic [7:0] STATUS_READ_CMD        = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD       = 8'h01;
    localparam logic [7:0] WRITE_LATCH_SET_CMD    = 8'h06;
    localparam logic [7:0] WRITE_LATCH_CLEAR_CMD  = 8'h04;
    localparam logic [7:0] DEVICE_CODE_READ_CMD   = 8'hAB;
    localparam logic [7:0] PART_CODE_READ_CMD     = 8'h9F;
    localparam logic [7:0] DEEP_SLEEP_CMD         = 8'hB9;

    typedef struct packed {
        logic has_addr;
        logic has_dummy;
        logic dual_addr;
        logic dual_data;
        logic rd;
        logic wr;
        logic need_write_latch_set_cmd;
    } info_t;

    function automatic info_t decode(input logic [7:0] op, input logic [8:0] len);
        info_t i;
        i = '0;
        case (op)
            READ_CMD:              begin i.has_addr = 1'b1; i.rd = 1'b1; end
            FAST_READ_CMD:         begin i.has_addr = 1'b1; i.has_dummy = 1'b1; i.rd = 1'b1; end
            DUAL_OUT_READ_CMD: begin
                i.has_addr  = 1'b1;
                i.has_dummy = 1'b1;
                i.dual_data = 1'b1;
                i.rd        = 1'b1;
            end
            DUAL_IO_READ_CMD: begin
                i.has_addr  = 1'b1;
                i.has_dummy = 1'b1;
                i.dual_addr = 1'b1;
                i.dual_data = 1'b1;
                i.rd        = 1'b1;
            end
            SECTOR_ERASE_CMD, SECTOR_ERASE_ALT_CMD, BLOCK_ERASE_CMD: begin
                i.has_addr  = 1'b1;
                i.need_write_latch_set_cmd = 1'b1;
            end
            CHIP_ERASE_CMD, CHIP_ERASE_ALT_CMD: i.need_write_latch_set_cmd = 1'b1;
            PAGE_PROGRAM_CMD:      begin i.has_addr = 1'b1; i.wr = 1'b1; i.need_write_latch_set_cmd = 1'b1; end
            STATUS_WRITE_CMD:      begin i.wr = 1'b1; i.need_write_latch_set_cmd = 1'b1; end
            STATUS_READ_CMD, PART_CODE_READ_CMD: i.rd = 1'b1;
            // with no data asked for, the bare opcode is the deep sleep exit
            DEVICE_CODE_READ_CMD:  begin i.has_addr = (len != 9'h000); i.rd = 1'b1; end
            default:               i = '0;
        endcase
        return i;
    endfunction

    // data bytes in the frame; program needs 1..256, status write exactly one
    function automatic logic [8:0] data_len(input logic [7:0] op, input logic [8:0] len);
        logic [8:0] n;
        n = len;
        if (op == STATUS_WRITE_CMD) begin
            n = 9'h001;
        end else if (op == PAGE_PROGRAM_CMD) begin
            if (len == 9'h000) begin
                n = 9'h001;
            end else if (len > PAGE_BYTES) begin
                n = PAGE_BYTES;
            end
        end
        return n;
    endfunction

endpackage

// File: verilog/sck_pacer.sv
`timescale 1ns/10ps
`default_nettype none

module sck_pacer
    import flash_host_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      tick_o
);

    logic [2:0] count;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count  <= 3'h0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            count  <= 3'h0;
            tick_o <= 1'b0;
        end else if (count == HALF_CYC - 3'h1) begin
            count  <= 3'h0;
            tick_o <= 1'b1;
        end else begin
            count  <= count + 3'h1;
            tick_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: dv/flash_host_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_checker (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       cmd_valid_i,
    input wire logic       cmd_ready_o,
    input wire logic       done_o,
    input wire logic       rd_valid_o,
    input wire logic       sck_o,
    input wire logic       cs_n_o,
    input wire logic [1:0] dual_data_lines_o,
    input wire logic [1:0] dual_data_lines_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic       sck_q;
    logic [7:0] rises;
    // rising serial edges in the current frame, modulo 256
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
            rises <= 8'h00;
        end else begin
            sck_q <= sck_o;
            rises <= cs_n_o ? 8'h00 : rises + 8'(sck_o && !sck_q);
        end
    end
    idle_deselect_a: assert property (cmd_ready_o |-> cs_n_o && !sck_o)
        else $error("selected or clocking while idle");
    sck_selected_a: assert property (sck_o |-> !cs_n_o)
        else $error("serial clock high while deselected");
    half_period_a: assert property ($changed(sck_o) |=> $stable(sck_o) [*4])
        else $error("serial clock half period below five cycles");
    select_lead_a: assert property ($fell(cs_n_o) |-> !sck_o [*5])
        else $error("clock edge too soon after select");
    data_on_low_a: assert property (!cs_n_o && |dual_data_lines_oe_o
        && $changed(dual_data_lines_o) |-> !sck_o)
        else $error("host data changed with clock high");
    whole_cycle_a: assert property ($rose(cs_n_o) |-> rises[1:0] == 2'b00)
        else $error("deselect inside a bus cycle");
    accept_select_a: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o && !cs_n_o)
        else $error("accepted command did not select");
    done_gap_a: assert property (done_o |-> cmd_ready_o && cs_n_o && $past(cs_n_o, 5))
        else $error("done without deselect gap");
    ready_done_a: assert property ($rose(cmd_ready_o) |-> done_o)
        else $error("ready returned without done");
    read_in_frame_a: assert property (rd_valid_o |-> !cs_n_o)
        else $error("read byte outside a frame");
    cover property (done_o);
    cover property (rd_valid_o && dual_data_lines_oe_o == 2'b00);
    cover property ($rose(cs_n_o) && rises == 8'd8);
endmodule
bind flash_host flash_host_checker i_flash_host_checker (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rd_valid_o(rd_valid_o),
    .sck_o(sck_o), .cs_n_o(cs_n_o), .dual_data_lines_o(dual_data_lines_o),
    .dual_data_lines_oe_o(dual_data_lines_oe_o));
`default_nettype wire

// File: dv/flash_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0]  DEV_CODE  = 8'h00,        // arbitrary
    parameter logic [31:0] PART_CODE = 32'h0000_0000 // arbitrary
) (
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic [1:0] line_i,
    output logic [1:0]      line_o,
    output logic [1:0]      line_oe_o
);
    logic [7:0]  op, sr, wbuf, b, ex_op;
    logic [23:0] adr, ex_adr;
    logic        wel = 1'b0, asleep = 1'b0, dual_d, rdop;
    logic [7:0]  mem [int];
    logic [7:0]  pq [$];
    int          nc = 0, nw, k, aclk, ds, ex_n = 0;
    initial line_oe_o = 2'b00;
    function automatic logic [7:0] rd_byte(input int i);
        logic [18:0] a;
        a = 19'(adr) + 19'(i);
        if (op == 8'h05) return sr;
        if (op == 8'hAB) return DEV_CODE;
        if (op == 8'h9F) return PART_CODE[31 - 8 * (i % 4) -: 8];
        return mem.exists(int'(a)) ? mem[int'(a)] : a[7:0] ^ 8'h5A;
    endfunction
    always_comb begin
        dual_d = op inside {8'h3B, 8'hBB};
        rdop   = op inside {8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h05, 8'hAB, 8'h9F};
        aclk   = op == 8'hBB ? 12 :
            op inside {8'h03, 8'h0B, 8'h3B, 8'h20, 8'hD7, 8'hD8, 8'h02, 8'hAB} ? 24 : 0;
        ds     = 8 + aclk + (op == 8'h0B ? 8 : dual_d ? 4 : 0);
    end
    always @(negedge cs_n_i) begin
        nc = 0;
        nw = 0;
        pq = {};
    end
    // same sampling whatever the clock's idle level
    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            if (nc < 8) begin
                op = {op[6:0], line_i[0]};
            end else if (nc < 8 + aclk) begin
                adr = aclk == 12 ? {adr[21:0], line_i} : {adr[22:0], line_i[0]};
            end else if (nc >= ds && !rdop) begin
                wbuf = {wbuf[6:0], line_i[0]};
                if ((nc - ds) % 8 == 7) begin
                    nw++;
                    pq.push_back(wbuf);
                end
            end
            nc++;
        end
    end
    always @(negedge sck_i) begin
        if (!cs_n_i && rdop && !asleep && nc >= ds) begin
            k = nc - ds;
            b = rd_byte(dual_d ? k / 4 : k / 8);
            line_oe_o = dual_d ? 2'b11 : 2'b10;
            line_o = dual_d ? 2'(b >> (6 - 2 * (k % 4))) : {b[7 - k % 8], 1'b0};
        end
    end
    always @(posedge cs_n_i) begin
        line_oe_o = 2'b00;
        if (nc >= 8 && nc % 8 == 0) begin
            if (asleep) begin
                asleep = !(op == 8'hAB && nc == 8);
            end else if (op == 8'h06 || op == 8'h04) begin
                wel = op == 8'h06;
            end else if (op == 8'hB9) begin
                asleep = 1'b1;
            end else if (wel && op inside {8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7, 8'h02, 8'h01}) begin
                wel = 1'b0;
                ex_op = op;
                ex_adr = adr;
                ex_n++;
                if (op == 8'h01 && nw == 1) sr = wbuf;
                if (op == 8'h02) begin
                    foreach (pq[i]) mem[int'({adr[18:8], adr[7:0] + 8'(i)})] = pq[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/flash_host_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_test;
    localparam logic [7:0]  ID_CODE = 8'h3C;       // arbitrary
    localparam logic [31:0] PART    = 32'hA1B2_C3D4; // arbitrary
    logic        ref_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, junk = 1'b0;
    logic        cmd_ready_o, wr_take_o, rd_valid_o, done_o, sck_o, cs_n_o;
    logic [7:0]  cmd_op_i = 8'h00, wr_data_i = 8'h00, rd_data_o;
    logic [23:0] cmd_addr_i = 24'h00_0000;
    logic [8:0]  cmd_len_i = 9'h000;
    logic [1:0]  dual_data_lines_i, dual_data_lines_o, dual_data_lines_oe_o, dev_o, dev_oe;
    logic [7:0]  rxq [$];
    int          n_errors = 0, samples_checked = 0;
    flash_host i_flash_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
        .cmd_ready_o(cmd_ready_o), .wr_data_i(wr_data_i), .wr_take_o(wr_take_o),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o), .sck_o(sck_o),
        .cs_n_o(cs_n_o), .dual_data_lines_i(dual_data_lines_i),
        .dual_data_lines_o(dual_data_lines_o), .dual_data_lines_oe_o(dual_data_lines_oe_o));
    flash_dev_model #(.DEV_CODE(ID_CODE), .PART_CODE(PART)) i_flash_dev_model (.sck_i(sck_o),
        .cs_n_i(cs_n_o), .line_i(dual_data_lines_i), .line_o(dev_o), .line_oe_o(dev_oe));
    // undriven lines carry a changing pattern, not a stale level
    always @(posedge ref_clk_i) junk <= ~junk;
    assign dual_data_lines_i = (dual_data_lines_oe_o & dual_data_lines_o)
        | (~dual_data_lines_oe_o & dev_oe & dev_o)
        | (~dual_data_lines_oe_o & ~dev_oe & {2{junk}});
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [8:0] n,
                       input logic [7:0] w);
        int t;
        rxq = {};
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i    <= op;
        cmd_addr_i  <= a;
        cmd_len_i   <= n;
        wr_data_i   <= w;
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        for (t = 0; t < 3000 && done_o !== 1'b1; t++) begin
            @(posedge ref_clk_i);
            if (rd_valid_o === 1'b1) rxq.push_back(rd_data_o);
            if (wr_take_o === 1'b1) wr_data_i <= wr_data_i + 8'h11;
        end
        check("done", 1, done_o);
    endtask
    task automatic t_plain_read();
        cmd(8'h03, 24'hFF_FFFF, 9'h002, 8'h00);
        check("rd adr", 24'h07_FFFF, i_flash_dev_model.adr);
        check("rd n", 2, rxq.size());
        check("rd b0", 8'hA5, rxq[0]);
        check("rd b1", 8'h5A, rxq[1]);
    endtask
    task automatic t_fast_reads();
        logic [7:0] ops [3] = '{8'h0B, 8'h3B, 8'hBB};
        for (int i = 0; i < 3; i++) begin
            cmd(ops[i], 24'h01_2340 + 24'(i), 9'h003, 8'h00);
            check("fast n", 3, rxq.size());
            for (int k = 0; k < 3; k++) check("fast", (8'h40 + 8'(i + k)) ^ 8'h5A, rxq[k]);
        end
    endtask
    task automatic t_program();
        int n0;
        n0 = i_flash_dev_model.ex_n;
        cmd(8'h02, 24'h00_01FE, 9'h002, 8'h3C);
        check("pg exec", n0 + 1, i_flash_dev_model.ex_n);
        check("pg latch", 0, i_flash_dev_model.wel);
        cmd(8'h03, 24'h00_01FE, 9'h003, 8'h00);
        check("pg b0", 8'h3C, rxq[0]);
        check("pg b1", 8'h4D, rxq[1]);
        check("pg b2", 8'h5A, rxq[2]);
    endtask
    task automatic t_erase();
        logic [7:0]  ops [5] = '{8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
        logic [23:0] exa [3] = '{24'h02_3000, 24'h02_3000, 24'h02_0000};
        for (int i = 0; i < 5; i++) begin
            cmd(ops[i], 24'hF2_3456, 9'h000, 8'h00);
            check("er op", ops[i], i_flash_dev_model.ex_op);
            if (i < 3) check("er adr", exa[i], i_flash_dev_model.ex_adr);
            check("er clks", i < 3 ? 32 : 8, i_flash_dev_model.nc);
        end
    endtask
    task automatic t_status();
        cmd(8'h01, 24'h00_0000, 9'h005, 8'h9C);
        check("sw clks", 16, i_flash_dev_model.nc);
        cmd(8'h05, 24'h00_0000, 9'h003, 8'h00);
        for (int k = 0; k < 3; k++) check("sr", 8'h9C, rxq[k]);
    endtask
    task automatic t_latch();
        cmd(8'h06, 24'h00_0000, 9'h000, 8'h00);
        check("latch set", 1, i_flash_dev_model.wel);
        cmd(8'h04, 24'h00_0000, 9'h000, 8'h00);
        check("latch clr", 0, i_flash_dev_model.wel);
    endtask
    task automatic t_ids();
        cmd(8'hAB, 24'h00_0000, 9'h002, 8'h00);
        check("id n", 2, rxq.size());
        for (int k = 0; k < 2; k++) check("id", ID_CODE, rxq[k]);
        cmd(8'h9F, 24'h00_0000, 9'h005, 8'h00);
        for (int k = 0; k < 5; k++) check("part", PART[31 - 8 * (k % 4) -: 8], rxq[k]);
    endtask
    task automatic t_sleep();
        cmd(8'hB9, 24'h00_0000, 9'h000, 8'h00);
        check("asleep", 1, i_flash_dev_model.asleep);
        cmd(8'hAB, 24'h00_0000, 9'h000, 8'h00);
        check("awake", 0, i_flash_dev_model.asleep);
        check("wake clks", 8, i_flash_dev_model.nc);
    endtask
    initial begin
        #80_000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_plain_read();
        t_fast_reads();
        t_program();
        t_erase();
        t_status();
        t_latch();
        t_ids();
        t_sleep();
        print_verdict();
    end
endmodule
`default_nettype wire
